// ===== design/ext_bus_defines.svh
// Timing and field constants for the external memory bus sequencer
`ifndef EXT_BUS_DEFINES_SVH
`define EXT_BUS_DEFINES_SVH

`define EB_STATES       3'h6
`define EB_LAST_STATE   3'h5
`define EB_STATE_FIVE   3'h4
`define EB_STATE_SIX    3'h5
`define EB_PHASE_ONE    1'h0
`define EB_PHASE_TWO    1'h1
`define EB_ADDR_LO_MSB  15
`define EB_ADDR_LO_LSB  8
`define EB_BYTE_ZERO    8'h00
`define EB_ADDR_ZERO    16'h0000
`define EB_ADDR_LOW_MSB 7
`define EB_ADDR_LOW_LSB 0

`define EB_TICK_STEP        4'h1
`define EB_TICK_ADDR0       4'h0
`define EB_TICK_ADDR1       4'h1
`define EB_TICK_ADDR_HOLD   4'h2
`define EB_TICK_FETCH_FIRST 4'h3
`define EB_TICK_FETCH_MID   4'h4
`define EB_TICK_FETCH_CAP   4'h5
`define EB_TICK_DATA_LOW1   4'h6
`define EB_TICK_DATA_LOW2   4'h7
`define EB_TICK_DATA_LOW3   4'h8
`define EB_TICK_DATA_LOW4   4'h9
`define EB_TICK_READ_CAP    4'ha
`define EB_TICK_LAST        4'hb

`endif

// ===== design/ext_bus_pkg.sv
// Types shared by the external memory bus sequencer
package ext_bus_pkg;
    typedef enum logic [1:0] {
        CYC_FETCH,
        CYC_READ,
        CYC_WRITE,
        CYC_IDLE
    } cycle_kind_t;
endpackage

// ===== design/machine_timer.sv
// Machine cycle state and phase counter
`timescale 1ns/1ps
`include "ext_bus_defines.svh"

module machine_timer (
    input  wire logic       mclk,
    input  wire logic       rst_n,
    output logic [2:0]      stateIdx,
    output logic            phase,
    output logic            cycleEnd
);
    logic [2:0] next_stateIdx;
    logic       next_phase;

    //--------------------------------
    // Six states of two phases
    //--------------------------------
    always_comb begin
        next_phase    = ~phase;
        next_stateIdx = stateIdx;
        if (phase == `EB_PHASE_TWO) begin
            if (stateIdx == `EB_LAST_STATE) begin
                next_stateIdx = 3'h0;
            end else begin
                next_stateIdx = stateIdx + 3'h1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            stateIdx <= 3'h0;
            phase    <= `EB_PHASE_ONE;
        end else begin
            stateIdx <= next_stateIdx; // R16
            phase    <= next_phase;
        end
    end

    assign cycleEnd = (phase == `EB_PHASE_TWO) && (stateIdx == `EB_LAST_STATE);
endmodule

// ===== design/external_memory_bus_cycles.sv
// External bus cycle sequencer: fetch, data read, data write, port timing
// Functional notes
// R1 - Fully static; halted clock loses no state
// R2 - Low address valid before latch strobe falls
// R3 - Low address held after latch strobe falls
// R4 - Address lines stable through each cycle
// R5 - Program memory data valid within two periods
// R6 - Program store strobe low three periods
// R7 - Instruction captured before program strobe rises
// R8 - Read strobe low six periods, late start
// R9 - Read data valid four periods after strobe
// R10 - Write data leads write strobe, six low
// R11 - Write data held one period after strobe
// R12 - Ports sampled state five, updated state six
// R13 - Port input setup before latch strobe falls
// R14 - Flash program pulse 290 to 310 microseconds; this design has no flash programming logic
// R15 - Flash mode needs reset, strobes held high; this design has no flash mode
// R16 - Machine cycle twelve periods, six states
`timescale 1ns/1ps
`include "ext_bus_defines.svh"

module external_memory_bus_cycles (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic [1:0]  reqKind,
    input  wire logic [15:0] reqAddr,
    input  wire logic [7:0]  reqWrData,
    output logic             reqReady,
    output logic [7:0]       rdData,
    output logic             rdValid,
    input  wire logic [7:0]  portOutData,
    output logic [7:0]       portInData,
    input  wire logic [7:0]  portPinIn,
    output logic [7:0]       portPinOut,
    output logic             addrLatchStrobe,
    output logic             program_store_strobe_n,
    output logic             readStrobe_n,
    output logic             writeStrobe_n,
    input  wire logic [7:0]  muxBusIn,
    output logic [7:0]       muxBusOut,
    output logic             muxBusOe,
    output logic [7:0]       highAddr
);
    logic [2:0] stateIdx;
    logic       phase;
    logic       cycleEnd;

    ext_bus_pkg::cycle_kind_t kind;
    ext_bus_pkg::cycle_kind_t next_kind;
    logic [15:0] addr;
    logic [15:0] next_addr;
    logic [7:0]  wrData;
    logic [7:0]  next_wrData;
    logic        dataCycle;
    logic        next_dataCycle;
    logic [7:0]  next_rdData;
    logic        next_rdValid;
    logic [7:0]  next_portInData;
    logic [7:0]  next_portPinOut;
    logic        next_ale;
    logic        next_progStrobe_n;
    logic        next_rd_n;
    logic        next_wr_n;
    logic [7:0]  next_muxBusOut;
    logic        next_muxBusOe;
    logic [7:0]  next_highAddr;

    machine_timer u_timer (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .stateIdx (stateIdx),
        .phase    (phase),
        .cycleEnd (cycleEnd)
    );

    // Tick index 0..11 within the machine cycle
    function automatic logic [3:0] tickOf(input logic [2:0] s, input logic p);
        tickOf = {s, 1'b0} + {3'h0, p};
    endfunction

    logic [3:0] tick;
    assign tick = tickOf(stateIdx, phase);

    // New request accepted only at machine cycle boundary
    assign reqReady = cycleEnd;

    //--------------------------------
    // Cycle selection and latching
    //--------------------------------
    always_comb begin
        next_kind      = kind;
        next_addr      = addr;
        next_wrData    = wrData;
        next_dataCycle = dataCycle;
        if (cycleEnd) begin
            next_kind      = ext_bus_pkg::cycle_kind_t'(reqKind);
            next_addr      = reqAddr;
            next_wrData    = reqWrData;
            next_dataCycle = (reqKind == 2'(ext_bus_pkg::CYC_READ))
                          || (reqKind == 2'(ext_bus_pkg::CYC_WRITE));
        end
    end

    // Tick that the registered outputs will show after this edge
    logic [3:0] nextTick;
    assign nextTick = cycleEnd ? `EB_TICK_ADDR0 : tick + `EB_TICK_STEP;

    // Active-low strobe level for a cycle of the wanted kind
    function automatic logic strobeIdle(input ext_bus_pkg::cycle_kind_t k,
                                        input ext_bus_pkg::cycle_kind_t want);
        strobeIdle = (k != want);
    endfunction

    // Plain clocked state only: a stopped clock freezes it
    always_ff @(posedge mclk) begin // R1
        if (!rst_n) begin
            kind      <= ext_bus_pkg::CYC_IDLE;
            addr      <= `EB_ADDR_ZERO;
            wrData    <= `EB_BYTE_ZERO;
            dataCycle <= 1'b0;
        end else begin
            kind      <= next_kind;
            addr      <= next_addr;
            wrData    <= next_wrData;
            dataCycle <= next_dataCycle;
        end
    end

    //--------------------------------
    // Strobe sequencing
    //--------------------------------
    // Latch strobe high ticks 0-1, falls at tick 2.
    // Fetch: program strobe low ticks 3-5.
    // Data: read or write strobe low ticks 5-10, three after the latch falls.
    always_comb begin
        next_ale          = 1'b0;
        next_progStrobe_n = 1'b1;
        next_rd_n         = 1'b1;
        next_wr_n         = 1'b1;
        if (next_kind != ext_bus_pkg::CYC_IDLE) begin
            unique case (nextTick)
                `EB_TICK_ADDR0: begin
                    next_ale = 1'b1; // R16
                end
                `EB_TICK_ADDR1: begin
                    next_ale = 1'b1; // R16
                end
                `EB_TICK_ADDR_HOLD: begin
                end
                `EB_TICK_FETCH_FIRST: begin
                    next_progStrobe_n = strobeIdle(kind, ext_bus_pkg::CYC_FETCH); // R6
                end
                `EB_TICK_FETCH_MID: begin
                    next_progStrobe_n = strobeIdle(kind, ext_bus_pkg::CYC_FETCH); // R6
                end
                `EB_TICK_FETCH_CAP: begin
                    next_progStrobe_n = strobeIdle(kind, ext_bus_pkg::CYC_FETCH); // R6
                    next_rd_n         = strobeIdle(kind, ext_bus_pkg::CYC_READ); // R8
                    next_wr_n         = strobeIdle(kind, ext_bus_pkg::CYC_WRITE); // R10
                end
                `EB_TICK_DATA_LOW1: begin
                    next_rd_n = strobeIdle(kind, ext_bus_pkg::CYC_READ); // R8
                    next_wr_n = strobeIdle(kind, ext_bus_pkg::CYC_WRITE); // R10
                end
                `EB_TICK_DATA_LOW2: begin
                    next_rd_n = strobeIdle(kind, ext_bus_pkg::CYC_READ); // R8
                    next_wr_n = strobeIdle(kind, ext_bus_pkg::CYC_WRITE); // R10
                end
                `EB_TICK_DATA_LOW3: begin
                    next_rd_n = strobeIdle(kind, ext_bus_pkg::CYC_READ); // R8
                    next_wr_n = strobeIdle(kind, ext_bus_pkg::CYC_WRITE); // R10
                end
                `EB_TICK_DATA_LOW4: begin
                    next_rd_n = strobeIdle(kind, ext_bus_pkg::CYC_READ); // R8
                    next_wr_n = strobeIdle(kind, ext_bus_pkg::CYC_WRITE); // R10
                end
                `EB_TICK_READ_CAP: begin
                    next_rd_n = strobeIdle(kind, ext_bus_pkg::CYC_READ); // R8
                    next_wr_n = strobeIdle(kind, ext_bus_pkg::CYC_WRITE); // R10
                end
                `EB_TICK_LAST: begin
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            addrLatchStrobe        <= 1'b0;
            program_store_strobe_n <= 1'b1;
            readStrobe_n           <= 1'b1;
            writeStrobe_n          <= 1'b1;
        end else begin
            addrLatchStrobe        <= next_ale;
            program_store_strobe_n <= next_progStrobe_n;
            readStrobe_n           <= next_rd_n;
            writeStrobe_n          <= next_wr_n;
        end
    end

    //--------------------------------
    // Multiplexed bus and high address
    //--------------------------------
    always_comb begin
        next_muxBusOut = muxBusOut;
        next_muxBusOe  = 1'b0;
        next_highAddr  = highAddr;
        if (next_kind != ext_bus_pkg::CYC_IDLE) begin
            unique case (nextTick)
                `EB_TICK_ADDR0: begin
                    next_muxBusOut = next_addr[`EB_ADDR_LOW_MSB:`EB_ADDR_LOW_LSB]; // R2
                    next_muxBusOe  = 1'b1;
                    next_highAddr  = next_addr[`EB_ADDR_LO_MSB:`EB_ADDR_LO_LSB]; // R4
                end
                `EB_TICK_ADDR1: begin
                    next_muxBusOut = next_addr[`EB_ADDR_LOW_MSB:`EB_ADDR_LOW_LSB]; // R2
                    next_muxBusOe  = 1'b1;
                    next_highAddr  = next_addr[`EB_ADDR_LO_MSB:`EB_ADDR_LO_LSB]; // R4
                end
                `EB_TICK_ADDR_HOLD: begin
                    next_muxBusOe = 1'b1; // R3
                end
                `EB_TICK_FETCH_FIRST: begin
                    if (kind == ext_bus_pkg::CYC_WRITE) begin
                        next_muxBusOut = wrData; // R10
                        next_muxBusOe  = 1'b1;
                    end
                end
                `EB_TICK_FETCH_MID: begin
                    if (kind == ext_bus_pkg::CYC_WRITE) begin
                        next_muxBusOut = wrData; // R10
                        next_muxBusOe  = 1'b1;
                    end
                end
                `EB_TICK_FETCH_CAP: begin
                    if (kind == ext_bus_pkg::CYC_WRITE) begin
                        next_muxBusOut = wrData; // R10
                        next_muxBusOe  = 1'b1;
                    end
                end
                `EB_TICK_DATA_LOW1: begin
                    next_muxBusOe = (kind == ext_bus_pkg::CYC_WRITE); // R10
                end
                `EB_TICK_DATA_LOW2: begin
                    next_muxBusOe = (kind == ext_bus_pkg::CYC_WRITE); // R10
                end
                `EB_TICK_DATA_LOW3: begin
                    next_muxBusOe = (kind == ext_bus_pkg::CYC_WRITE); // R10
                end
                `EB_TICK_DATA_LOW4: begin
                    next_muxBusOe = (kind == ext_bus_pkg::CYC_WRITE); // R10
                end
                `EB_TICK_READ_CAP: begin
                    next_muxBusOe = (kind == ext_bus_pkg::CYC_WRITE); // R10
                end
                `EB_TICK_LAST: begin
                    next_muxBusOe = (kind == ext_bus_pkg::CYC_WRITE); // R11
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            muxBusOut <= `EB_BYTE_ZERO;
            muxBusOe  <= 1'b0;
            highAddr  <= `EB_BYTE_ZERO;
        end else begin
            muxBusOut <= next_muxBusOut;
            muxBusOe  <= next_muxBusOe;
            highAddr  <= next_highAddr;
        end
    end

    //--------------------------------
    // Byte capture and port timing
    //--------------------------------
    always_comb begin
        next_rdData     = rdData;
        next_rdValid    = 1'b0;
        next_portInData = portInData;
        next_portPinOut = portPinOut;
        // Fetch byte taken while the program strobe is still low
        if (kind == ext_bus_pkg::CYC_FETCH && tick == `EB_TICK_FETCH_CAP) begin
            next_rdData  = muxBusIn; // R7
            next_rdValid = 1'b1;
        end
        // Read byte taken on the last low tick of the read strobe
        if (kind == ext_bus_pkg::CYC_READ && tick == `EB_TICK_READ_CAP) begin
            next_rdData  = muxBusIn; // R8
            next_rdValid = 1'b1;
        end
        if (stateIdx == `EB_STATE_FIVE && phase == `EB_PHASE_TWO) begin
            next_portInData = portPinIn; // R12
        end
        if (stateIdx == `EB_STATE_SIX && phase == `EB_PHASE_TWO) begin
            next_portPinOut = portOutData; // R12
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rdData     <= `EB_BYTE_ZERO;
            rdValid    <= 1'b0;
            portInData <= `EB_BYTE_ZERO;
            portPinOut <= `EB_BYTE_ZERO;
        end else begin
            rdData     <= next_rdData;
            rdValid    <= next_rdValid;
            portInData <= next_portInData;
            portPinOut <= next_portPinOut;
        end
    end
endmodule

// ===== verification/ext_mem_model.sv
// External program and data memory on the far side of the multiplexed bus
`timescale 1ns/1ps
module ext_mem_model (
    input  wire logic       mclk,
    input  wire logic       slow,
    input  wire logic       addrLatchStrobe,
    input  wire logic       program_store_strobe_n,
    input  wire logic       readStrobe_n,
    input  wire logic       writeStrobe_n,
    input  wire logic [7:0] muxBusOut,
    input  wire logic       muxBusOe,
    output logic      [7:0] muxBusIn
);
    logic [7:0] mem [256];
    logic [7:0] addrLo = 8'h00;
    logic [2:0] lowCnt = 3'h0;
    logic       valid;
    initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'ha5;
    always @(posedge mclk) begin
        if (addrLatchStrobe) addrLo <= muxBusOut;
        lowCnt <= (program_store_strobe_n && readStrobe_n) ? 3'h0 : lowCnt + 3'h1;
        if (!writeStrobe_n) mem[addrLo] <= muxBusOut;
    end
    // Slow answers land just inside the access limit
    assign valid = !program_store_strobe_n ? lowCnt >= (slow ? 3'h1 : 3'h0)
                 : !readStrobe_n && lowCnt >= (slow ? 3'h3 : 3'h0);
    // Never enters flash mode, so no program pulse is applied
    // Undriven bus shows inverted data, no hold after strobe rises
    assign muxBusIn = muxBusOe ? muxBusOut : valid ? mem[addrLo] : ~mem[addrLo];
endmodule

// ===== verification/external_memory_bus_cycles_checker.sv
// Protocol checker for the external memory bus sequencer
`timescale 1ns/1ps
module external_memory_bus_cycles_checker (
    input wire logic       mclk,
    input wire logic       rst_n,
    input wire logic       reqReady,
    input wire logic       rdValid,
    input wire logic       addrLatchStrobe,
    input wire logic       program_store_strobe_n,
    input wire logic       readStrobe_n,
    input wire logic       writeStrobe_n,
    input wire logic [7:0] muxBusOut,
    input wire logic       muxBusOe,
    input wire logic [7:0] highAddr
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // ----------------------------------------
    // Bus cycle relations
    // ----------------------------------------
    a_cycle_period: assert property (reqReady |=> !reqReady [*8] ##1 !reqReady [*3] ##1 reqReady)
        else $error("machine cycle not twelve periods");
    a_addr_setup: assert property ($fell(addrLatchStrobe) |-> $past(muxBusOe) && $stable(muxBusOut))
        else $error("low address not set up before latch");
    a_addr_hold: assert property ($fell(addrLatchStrobe) |-> muxBusOe && $stable(muxBusOut))
        else $error("low address not held after latch");
    a_high_stable: assert property (!(program_store_strobe_n && readStrobe_n && writeStrobe_n)
        |-> $stable(highAddr))
        else $error("high address moved during strobe");
    a_fetch_width: assert property ($fell(program_store_strobe_n)
        |-> !program_store_strobe_n [*3] ##1 program_store_strobe_n)
        else $error("program strobe width wrong");
    a_read_width: assert property ($fell(readStrobe_n) |-> !readStrobe_n [*6] ##1 readStrobe_n)
        else $error("read strobe width wrong");
    a_strobe_start: assert property ($fell(readStrobe_n) || $fell(writeStrobe_n)
        |-> $past(addrLatchStrobe, 4) && !$past(addrLatchStrobe, 3))
        else $error("data strobe not three periods after latch");
    a_write_width: assert property ($fell(writeStrobe_n) |-> !writeStrobe_n [*6] ##1 writeStrobe_n)
        else $error("write strobe width wrong");
    a_write_lead: assert property ($fell(writeStrobe_n) |-> muxBusOe && $past(muxBusOe) && $stable(muxBusOut))
        else $error("write data not ahead of strobe");
    a_write_hold: assert property ($rose(writeStrobe_n) |-> muxBusOe && $stable(muxBusOut))
        else $error("write data not held after strobe");
    a_capture_strobe: assert property (rdValid |-> !$past(program_store_strobe_n) || !$past(readStrobe_n))
        else $error("byte captured outside strobe");
    c_fetch: cover property ($fell(program_store_strobe_n));
    c_read: cover property ($fell(readStrobe_n));
    c_write: cover property ($rose(writeStrobe_n));
endmodule

// ===== verification/external_memory_bus_cycles_test.sv
// Self-checking bench for the external memory bus sequencer
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin num_errors++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module external_memory_bus_cycles_test;
    logic        mclk = 1'b0, rst_n = 1'b0, halt = 1'b0, slow = 1'b0;
    logic [1:0]  reqKind = ext_bus_pkg::CYC_IDLE;
    logic [15:0] reqAddr = 16'h0000;
    logic [7:0]  reqWrData = 8'h00, portOutData = 8'h00, portPinIn = 8'h00;
    logic [7:0]  rdData, portInData, portPinOut, muxBusIn, muxBusOut, highAddr;
    logic        reqReady, rdValid, addrLatchStrobe, muxBusOe;
    logic        program_store_strobe_n, readStrobe_n, writeStrobe_n;
    int          num_errors = 0, check_count = 0;
    always #10 mclk = halt ? mclk : ~mclk;
    external_memory_bus_cycles uut (
        .mclk                   (mclk),
        .rst_n                  (rst_n),
        .reqKind                (reqKind),
        .reqAddr                (reqAddr),
        .reqWrData              (reqWrData),
        .reqReady               (reqReady),
        .rdData                 (rdData),
        .rdValid                (rdValid),
        .portOutData            (portOutData),
        .portInData             (portInData),
        .portPinIn              (portPinIn),
        .portPinOut             (portPinOut),
        .addrLatchStrobe        (addrLatchStrobe),
        .program_store_strobe_n (program_store_strobe_n),
        .readStrobe_n           (readStrobe_n),
        .writeStrobe_n          (writeStrobe_n),
        .muxBusIn               (muxBusIn),
        .muxBusOut              (muxBusOut),
        .muxBusOe               (muxBusOe),
        .highAddr               (highAddr)
    );
    ext_mem_model mem (
        .mclk                   (mclk),
        .slow                   (slow),
        .addrLatchStrobe        (addrLatchStrobe),
        .program_store_strobe_n (program_store_strobe_n),
        .readStrobe_n           (readStrobe_n),
        .writeStrobe_n          (writeStrobe_n),
        .muxBusOut              (muxBusOut),
        .muxBusOe               (muxBusOe),
        .muxBusIn               (muxBusIn)
    );
    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic issue(input logic [1:0] k, input logic [15:0] a, input logic [7:0] d);
        int n;
        n = 0;
        reqKind = k; reqAddr = a; reqWrData = d;
        while (reqReady !== 1'b1 && n < 40) begin @(posedge mclk); #1; n++; end
        if (n == 40) begin num_errors++; final_report(); end
        @(posedge mclk); #1;
        reqKind = ext_bus_pkg::CYC_IDLE;
    endtask
    task automatic expect_byte(input logic [7:0] e);
        int n;
        n = 0;
        while (rdValid !== 1'b1 && n < 40) begin @(posedge mclk); #1; n++; end
        if (n == 40) begin num_errors++; final_report(); end
        `CHK("captured byte", e, rdData)
    endtask
    task automatic t_fetch;
        for (int s = 0; s < 2; s++) begin
            slow = 1'(s);
            issue(ext_bus_pkg::CYC_FETCH, {8'h12, 8'(8'h34 + s)}, 8'h00);
            expect_byte(8'(8'h34 + s) ^ 8'ha5);
            `CHK("high address", 8'h12, highAddr)
        end
        $display("fetch test done");
    endtask
    task automatic t_write_read;
        for (int i = 0; i < 2; i++) begin
            slow = 1'(i);
            issue(ext_bus_pkg::CYC_WRITE, 16'h5a40, 8'h3c ^ 8'(i));
            issue(ext_bus_pkg::CYC_READ, 16'h5a40, 8'h00);
            repeat (4) @(posedge mclk);
            // Halt once high and once low
            #(1 + 10 * i) halt = 1'b1;
            #500 halt = 1'b0;
            expect_byte(8'h3c ^ 8'(i));
        end
        $display("write read test done");
    endtask
    task automatic t_ports;
        portOutData = 8'h96;
        portPinIn = 8'h5b;
        repeat (26) @(posedge mclk);
        #1;
        `CHK("port output", 8'h96, portPinOut)
        `CHK("port input", 8'h5b, portInData)
        $display("port test done");
    endtask
    initial begin
        repeat (12) @(posedge mclk);
        #1 rst_n = 1'b1;
        t_fetch();
        t_write_read();
        t_ports();
        final_report();
    end
endmodule
bind external_memory_bus_cycles external_memory_bus_cycles_checker chk (
    .mclk                   (mclk),
    .rst_n                  (rst_n),
    .reqReady               (reqReady),
    .rdValid                (rdValid),
    .addrLatchStrobe        (addrLatchStrobe),
    .program_store_strobe_n (program_store_strobe_n),
    .readStrobe_n           (readStrobe_n),
    .writeStrobe_n          (writeStrobe_n),
    .muxBusOut              (muxBusOut),
    .muxBusOe               (muxBusOe),
    .highAddr               (highAddr)
);
